/* File: rtl/rid_decode.sv */
// What this block does
// - Each instruction is one fixed 32-bit word, fields in fixed places.
// - Instructions are four bytes long and sit on word-aligned addresses.
// - Integer memory ops move byte, half or word to 32 general registers.
// - Float loads/stores move word or double with 32 float registers.
// - Float math uses single (word) and double (double word) operands.
// - Computational instructions never write memory; only stores do.
// - Effective addresses use 32-bit unsigned sums, carry out discarded.
// - Reserve-load and conditional-store decode as load/store operations.
// - Processor control: special and machine-state moves, syncs, ordering.
// - Vector LRU loads/stores leave touched cache entries least-recent.
// - Transient stream touches and vector LRU forms are tagged transient.
// - Decode vector pack/unpack/merge/splat/permute/select/shift.
// - Vector control ops read and write the vector status register.
// - All base 32-bit instructions execute in hardware, none emulated; only listed opcodes decode, all others flag illegal and divert.
// - Accept optional I/O, allocate, select, estimates, int store, TLB.
// - Flow diverts on an interrupting instruction or an async event.
`timescale 1ns/1ps
`default_nettype none

module rid_decode (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    arst_n,
  // Fetch side
  input  wire logic                    fetch_valid,
  input  wire rid_pkg::rid_fetch_t     fetch,
  input  wire logic [31:0]             ra_value,
  input  wire logic                    async_event,
  // Decode result
  output var  logic                    dec_valid_r,
  output var  rid_pkg::rid_decode_t    dec_r,
  output var  logic                    divert_r
);

  ////////////////////////////////////////////////////////////////////////////
  rid_pkg::rid_decode_t d;
  logic [5:0]  opc;
  logic [9:0]  xo;
  logic [4:0]  axo;
  logic [10:0] vxo;
  logic [31:0] simm;
  logic        misalign;

  assign opc  = fetch.word[rid_pkg::OPC_HI:rid_pkg::OPC_LO];
  assign xo   = fetch.word[rid_pkg::XO_HI:rid_pkg::XO_LO];
  assign axo  = fetch.word[rid_pkg::AXO_HI:rid_pkg::AXO_LO];
  assign vxo  = fetch.word[rid_pkg::VXO_HI:rid_pkg::VXO_LO];
  assign simm = {{16{fetch.word[15]}}, fetch.word[15:0]};
  // Low two address bits must be zero
  assign misalign = fetch.addr[1:0] != rid_pkg::ALIGN_ZERO;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d = '0;
    d.group = rid_pkg::RID_GRP_NONE;
    d.size  = rid_pkg::RID_SZ_WORD;
    d.illegal = 1'b1;
    d.rd  = fetch.word[25:21];
    d.ra  = fetch.word[20:16];
    d.rb  = fetch.word[15:11];
    d.pc  = fetch.addr;
    // Wraps naturally; carry beyond 32 bits dropped
    d.ea  = ra_value + simm;
    unique case (opc)
      rid_pkg::OP_TWI, rid_pkg::OP_B, rid_pkg::OP_BC, rid_pkg::OP_SC: begin
        d.group = rid_pkg::RID_GRP_FLOW;
        d.trap_flow = (opc == rid_pkg::OP_TWI) || (opc == rid_pkg::OP_SC);
        d.illegal = 1'b0;
      end
      rid_pkg::OP_CR: begin
        d.group = rid_pkg::RID_GRP_FLOW;
        d.illegal = 1'b0;
        if (xo == rid_pkg::XO_ISYNC) begin
          d.group = rid_pkg::RID_GRP_PCTL;
          d.sync_op = 1'b1;
        end else if (xo == rid_pkg::XO_RFI) begin
          d.msr_move = 1'b1;
        end else if (!(xo == rid_pkg::XO_BCLR || xo == rid_pkg::XO_BCCTR
                       || xo[4:0] == rid_pkg::XO_CRAND[4:0])) begin
          d.illegal = 1'b1;
        end
      end
      rid_pkg::OP_MULLI, rid_pkg::OP_SUBFIC, rid_pkg::OP_CMPLI,
      rid_pkg::OP_CMPI, rid_pkg::OP_ADDIC, rid_pkg::OP_ADDICR,
      rid_pkg::OP_ADDI, rid_pkg::OP_ADDIS, rid_pkg::OP_RLWIMI,
      rid_pkg::OP_RLWINM, rid_pkg::OP_RLWNM: begin
        d.group = rid_pkg::RID_GRP_INT;
        d.illegal = 1'b0;
      end
      rid_pkg::OP_VEC: begin
        d.illegal = 1'b0;
        if (vxo == rid_pkg::VXO_MTVSCR || vxo == rid_pkg::VXO_MFVSCR) begin
          d.group = rid_pkg::RID_GRP_VPCTL;
          d.vscr_access = 1'b1;
        end else if (vxo[5:0] == rid_pkg::VA_VPERM
                     || vxo[5:0] == rid_pkg::VA_VSEL
                     || vxo == rid_pkg::VXO_VPKUHUM
                     || vxo == rid_pkg::VXO_VUPKHSB
                     || vxo == rid_pkg::VXO_VMRGHB
                     || vxo == rid_pkg::VXO_VSPLTB
                     || vxo == rid_pkg::VXO_VSLO) begin
          d.group = rid_pkg::RID_GRP_VPERM;
        end else if (vxo == rid_pkg::VXO_VADDFP) begin
          d.group = rid_pkg::RID_GRP_VFP;
        end else if (vxo == rid_pkg::VXO_VADDUBM) begin
          d.group = rid_pkg::RID_GRP_VINT;
        end else begin
          d.illegal = 1'b1;
        end
      end
      rid_pkg::OP_X: begin
        d.illegal = 1'b0;
        unique case (xo)
          rid_pkg::XO_LWARX: begin
            d.group = rid_pkg::RID_GRP_LDST;
            d.is_load = 1'b1;
            d.reserve = 1'b1;
          end
          rid_pkg::XO_STWCX: begin
            d.group = rid_pkg::RID_GRP_LDST;
            d.is_store = 1'b1;
            d.cond_store = 1'b1;
          end
          rid_pkg::XO_MFSPR, rid_pkg::XO_MTSPR, rid_pkg::XO_MFTB: begin
            d.group = rid_pkg::RID_GRP_PCTL;
            d.spr_move = 1'b1;
          end
          rid_pkg::XO_MFMSR, rid_pkg::XO_MTMSR: begin
            d.group = rid_pkg::RID_GRP_PCTL;
            d.msr_move = 1'b1;
          end
          rid_pkg::XO_SYNC, rid_pkg::XO_EIEIO: begin
            d.group = rid_pkg::RID_GRP_PCTL;
            d.sync_op = 1'b1;
          end
          rid_pkg::XO_ECIWX, rid_pkg::XO_ECOWX: begin
            d.group = rid_pkg::RID_GRP_LDST;
            d.optional_op = 1'b1;
            d.is_load = (xo == rid_pkg::XO_ECIWX);
            d.is_store = (xo == rid_pkg::XO_ECOWX);
          end
          rid_pkg::XO_DCBA, rid_pkg::XO_TLBLD, rid_pkg::XO_TLBLI: begin
            d.group = rid_pkg::RID_GRP_MCTL;
            d.optional_op = 1'b1;
          end
          rid_pkg::XO_STFIWX: begin
            d.group = rid_pkg::RID_GRP_LDST;
            d.optional_op = 1'b1;
            d.is_store = 1'b1;
            d.is_fpr = 1'b1;
          end
          rid_pkg::XO_DST, rid_pkg::XO_DSTST: begin
            d.group = rid_pkg::RID_GRP_VMCTL;
            // Transient form selected by bit 25
            d.transient = fetch.word[25];
          end
          rid_pkg::XO_LVX, rid_pkg::XO_LVXL: begin
            d.group = rid_pkg::RID_GRP_VLDST;
            d.is_load = 1'b1;
            d.lru_hint = (xo == rid_pkg::XO_LVXL);
            d.transient = (xo == rid_pkg::XO_LVXL);
          end
          rid_pkg::XO_STVX, rid_pkg::XO_STVXL: begin
            d.group = rid_pkg::RID_GRP_VLDST;
            d.is_store = 1'b1;
            d.lru_hint = (xo == rid_pkg::XO_STVXL);
            d.transient = (xo == rid_pkg::XO_STVXL);
          end
          rid_pkg::XO_LBZX, rid_pkg::XO_STBX: begin
            d.group = rid_pkg::RID_GRP_LDST;
            d.size = rid_pkg::RID_SZ_BYTE;
            d.is_load = (xo == rid_pkg::XO_LBZX);
            d.is_store = (xo == rid_pkg::XO_STBX);
          end
          rid_pkg::XO_LHZX, rid_pkg::XO_STHX: begin
            d.group = rid_pkg::RID_GRP_LDST;
            d.size = rid_pkg::RID_SZ_HALF;
            d.is_load = (xo == rid_pkg::XO_LHZX);
            d.is_store = (xo == rid_pkg::XO_STHX);
          end
          rid_pkg::XO_LWZX, rid_pkg::XO_STWX: begin
            d.group = rid_pkg::RID_GRP_LDST;
            d.is_load = (xo == rid_pkg::XO_LWZX);
            d.is_store = (xo == rid_pkg::XO_STWX);
          end
          rid_pkg::XO_LFSX, rid_pkg::XO_STFDX: begin
            d.group = rid_pkg::RID_GRP_LDST;
            d.is_fpr = 1'b1;
            d.is_load = (xo == rid_pkg::XO_LFSX);
            d.is_store = (xo == rid_pkg::XO_STFDX);
            d.is_double = (xo == rid_pkg::XO_STFDX);
            d.size = d.is_double ? rid_pkg::RID_SZ_DWORD
                                 : rid_pkg::RID_SZ_WORD;
          end
          rid_pkg::XO_TW: begin
            d.group = rid_pkg::RID_GRP_FLOW;
            d.trap_flow = 1'b1;
          end
          rid_pkg::XO_ADD, rid_pkg::XO_AND, rid_pkg::XO_OR,
          rid_pkg::XO_CMP, rid_pkg::XO_SLW: begin
            d.group = rid_pkg::RID_GRP_INT;
          end
          default: d.illegal = 1'b1;
        endcase
      end
      rid_pkg::OP_FPS, rid_pkg::OP_FPD: begin
        d.group = rid_pkg::RID_GRP_FP;
        // Single on 59, double on 63
        d.is_double = (opc == rid_pkg::OP_FPD);
        d.size = d.is_double ? rid_pkg::RID_SZ_DWORD : rid_pkg::RID_SZ_WORD;
        d.illegal = 1'b0;
        if (axo == rid_pkg::AXO_FSEL || axo == rid_pkg::AXO_FRES
            || axo == rid_pkg::AXO_FRSQRTE) begin
          d.optional_op = 1'b1;
        end else if (!(axo == rid_pkg::AXO_FADD || axo == rid_pkg::AXO_FMUL
                       || axo == rid_pkg::AXO_FMADD)) begin
          d.illegal = 1'b1;
        end
      end
      default: begin
        if (opc >= rid_pkg::OP_ORI && opc <= rid_pkg::OP_ANDISR) begin
          d.group = rid_pkg::RID_GRP_INT;
          d.illegal = 1'b0;
        end else if (opc >= rid_pkg::OP_LWZ && opc <= rid_pkg::OP_STMW) begin
          // D-form integer memory ops by opcode pattern
          d.group = rid_pkg::RID_GRP_LDST;
          d.illegal = 1'b0;
          // Load/store multiple (top pair) is word sized, low bit stores
          d.is_store = (opc[3:1] == 3'h7) ? opc[0] : opc[2];
          d.is_load = !d.is_store;
          d.size = (opc[3:1] == 3'h7) ? rid_pkg::RID_SZ_WORD
                 : opc[3] ? rid_pkg::RID_SZ_HALF
                 : (opc[1] ? rid_pkg::RID_SZ_BYTE : rid_pkg::RID_SZ_WORD);
        end else if (opc >= rid_pkg::OP_LFS && opc <= rid_pkg::OP_STFDU) begin
          d.group = rid_pkg::RID_GRP_LDST;
          d.illegal = 1'b0;
          d.is_fpr = 1'b1;
          d.is_store = opc[2];
          d.is_load = !opc[2];
          d.is_double = opc[1];
          d.size = opc[1] ? rid_pkg::RID_SZ_DWORD : rid_pkg::RID_SZ_WORD;
        end
      end
    endcase
    // Misaligned fetch is never executed
    if (misalign) begin
      d.illegal = 1'b1;
    end
    // Only stores may write memory
    d.mem_write = d.is_store && !d.illegal;
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dec_valid_r <= 1'b0;
    end else begin
      dec_valid_r <= fetch_valid;
    end
  end

  // Held between fetches so a stalled consumer still sees it
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      dec_r <= '0;
    end else if (fetch_valid) begin
      dec_r <= d;
    end
  end

  // Divert on interrupting insn or async event
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      divert_r <= 1'b0;
    end else begin
      divert_r <= async_event
                  || (fetch_valid && (d.illegal || d.trap_flow));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions, one clock domain; reset aborts every attempt
  default clocking cb_core @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  AST_VALID_PIPE: assert property (
    fetch_valid |=> dec_valid_r)
    else $error("decode result missing one cycle after fetch");
  AST_ILLEGAL_DIVERTS: assert property (
    dec_valid_r && dec_r.illegal |-> divert_r)
    else $error("illegal decode without divert");
  AST_ALIGN: assert property (
    fetch_valid && fetch.addr[1:0] != rid_pkg::ALIGN_ZERO |=> dec_r.illegal)
    else $error("misaligned fetch not flagged");
  // Group checked too, so a stray store flag on a math op is caught
  AST_NO_COMP_WRITE: assert property (
    dec_valid_r && dec_r.mem_write |-> dec_r.is_store && !dec_r.is_load
      && dec_r.group inside {rid_pkg::RID_GRP_LDST, rid_pkg::RID_GRP_VLDST})
    else $error("non-store writes memory");
  AST_LOAD_STORE_EXCL: assert property (
    dec_valid_r |-> !(dec_r.is_load && dec_r.is_store))
    else $error("word decoded as both load and store");
  AST_LRU_TRANSIENT: assert property (
    dec_valid_r && dec_r.lru_hint
      |-> dec_r.transient && dec_r.group == rid_pkg::RID_GRP_VLDST)
    else $error("lru form not transient vector access");
  AST_TRANSIENT_GROUP: assert property (
    dec_valid_r && dec_r.transient
      |-> dec_r.group inside {rid_pkg::RID_GRP_VLDST, rid_pkg::RID_GRP_VMCTL})
    else $error("transient tag outside vector memory ops");
  AST_RESERVE: assert property (
    fetch_valid && opc == rid_pkg::OP_X && xo == rid_pkg::XO_LWARX
      && !misalign |=> dec_r.reserve && dec_r.is_load
      && dec_r.group == rid_pkg::RID_GRP_LDST)
    else $error("reserve load misdecoded");
  AST_VSCR: assert property (
    dec_valid_r && dec_r.vscr_access
      |-> dec_r.group == rid_pkg::RID_GRP_VPCTL)
    else $error("vscr access outside vector control");
  AST_ASYNC: assert property (
    async_event |=> divert_r)
    else $error("async event not diverted");
  AST_EA_WRAP: assert property (
    fetch_valid |=> dec_r.ea == 32'($past(ra_value) + $past(simm)))
    else $error("effective address mismatch");
  // Ties is_double to the opcode, and size to is_double, the flag the size was built from
  AST_FP_SIZE: assert property (
    fetch_valid && (opc == rid_pkg::OP_FPS || opc == rid_pkg::OP_FPD)
      |=> dec_r.is_double == ($past(opc) == rid_pkg::OP_FPD)
      && dec_r.is_double == (dec_r.size == rid_pkg::RID_SZ_DWORD))
    else $error("float size mismatch");

  COV_ILLEGAL: cover property (dec_valid_r && dec_r.illegal);
  COV_COND_STORE: cover property (dec_valid_r && dec_r.cond_store);
  COV_OPTIONAL: cover property (dec_valid_r && dec_r.optional_op);
  COV_VPERM: cover property (
    dec_valid_r && dec_r.group == rid_pkg::RID_GRP_VPERM);

endmodule // rid_decode

`default_nettype wire

/* File: rtl/rid_pkg.sv */
package rid_pkg;

  // Instruction word geometry
  localparam int          INSN_W        = 32;
  localparam int          INSN_BYTES    = 4;
  localparam int          ADDR_W        = 32;
  localparam int          REG_IDX_W     = 5;
  localparam logic [1:0]  ALIGN_ZERO    = 2'h0;

  // Primary opcode field, bits 31:26 in the low-to-high numbering used here
  localparam int          OPC_HI        = 31;
  localparam int          OPC_LO        = 26;
  localparam int          XO_HI         = 10;
  localparam int          XO_LO         = 1;
  localparam int          AXO_HI        = 5;
  localparam int          AXO_LO        = 1;
  localparam int          VXO_HI        = 10;
  localparam int          VXO_LO        = 0;

  // Primary opcodes
  localparam logic [5:0] OP_TWI   = 6'h03;
  localparam logic [5:0] OP_VEC   = 6'h04;
  localparam logic [5:0] OP_MULLI = 6'h07;
  localparam logic [5:0] OP_SUBFIC= 6'h08;
  localparam logic [5:0] OP_CMPLI = 6'h0A;
  localparam logic [5:0] OP_CMPI  = 6'h0B;
  localparam logic [5:0] OP_ADDIC = 6'h0C;
  localparam logic [5:0] OP_ADDICR= 6'h0D;
  localparam logic [5:0] OP_ADDI  = 6'h0E;
  localparam logic [5:0] OP_ADDIS = 6'h0F;
  localparam logic [5:0] OP_BC    = 6'h10;
  localparam logic [5:0] OP_SC    = 6'h11;
  localparam logic [5:0] OP_B     = 6'h12;
  localparam logic [5:0] OP_CR    = 6'h13;
  localparam logic [5:0] OP_RLWIMI= 6'h14;
  localparam logic [5:0] OP_RLWINM= 6'h15;
  localparam logic [5:0] OP_RLWNM = 6'h17;
  localparam logic [5:0] OP_ORI   = 6'h18;
  localparam logic [5:0] OP_ANDISR= 6'h1D;
  localparam logic [5:0] OP_X     = 6'h1F;
  localparam logic [5:0] OP_LWZ   = 6'h20;
  localparam logic [5:0] OP_STMW  = 6'h2F;
  localparam logic [5:0] OP_LFS   = 6'h30;
  localparam logic [5:0] OP_STFDU = 6'h37;
  localparam logic [5:0] OP_FPS   = 6'h3B;
  localparam logic [5:0] OP_FPD   = 6'h3F;

  // Extended opcodes, primary 31; XO_ISYNC is primary 19
  localparam logic [9:0] XO_LWARX  = 10'h014;
  localparam logic [9:0] XO_STWCX  = 10'h096;
  localparam logic [9:0] XO_MFMSR  = 10'h053;
  localparam logic [9:0] XO_MTMSR  = 10'h092;
  localparam logic [9:0] XO_MFSPR  = 10'h153;
  localparam logic [9:0] XO_MTSPR  = 10'h1D3;
  localparam logic [9:0] XO_SYNC   = 10'h256;
  localparam logic [9:0] XO_EIEIO  = 10'h356;
  localparam logic [9:0] XO_ECIWX  = 10'h136;
  localparam logic [9:0] XO_ECOWX  = 10'h1B6;
  localparam logic [9:0] XO_DCBA   = 10'h2F6;
  localparam logic [9:0] XO_STFIWX = 10'h3D7;
  localparam logic [9:0] XO_TLBLD  = 10'h3D2;
  localparam logic [9:0] XO_TLBLI  = 10'h3F2;
  localparam logic [9:0] XO_DST    = 10'h156;
  localparam logic [9:0] XO_DSTST  = 10'h176;
  localparam logic [9:0] XO_LVX    = 10'h067;
  localparam logic [9:0] XO_LVXL   = 10'h167;
  localparam logic [9:0] XO_STVX   = 10'h0E7;
  localparam logic [9:0] XO_STVXL  = 10'h1E7;
  localparam logic [9:0] XO_MFTB   = 10'h173;
  localparam logic [9:0] XO_ISYNC  = 10'h096;
  localparam logic [9:0] XO_ADD    = 10'h10A;
  localparam logic [9:0] XO_AND    = 10'h01C;
  localparam logic [9:0] XO_OR     = 10'h1BC;
  localparam logic [9:0] XO_CMP    = 10'h000;
  localparam logic [9:0] XO_SLW    = 10'h018;
  localparam logic [9:0] XO_TW     = 10'h004;
  localparam logic [9:0] XO_LWZX   = 10'h017;
  localparam logic [9:0] XO_STWX   = 10'h097;
  localparam logic [9:0] XO_LBZX   = 10'h057;
  localparam logic [9:0] XO_STBX   = 10'h0D7;
  localparam logic [9:0] XO_LHZX   = 10'h117;
  localparam logic [9:0] XO_STHX   = 10'h197;
  localparam logic [9:0] XO_LFSX   = 10'h217;
  localparam logic [9:0] XO_STFDX  = 10'h2D7;

  // Extended opcodes, primary 19
  localparam logic [9:0] XO_BCLR   = 10'h010;
  localparam logic [9:0] XO_BCCTR  = 10'h210;
  localparam logic [9:0] XO_RFI    = 10'h032;
  localparam logic [9:0] XO_CRAND  = 10'h101;

  // A-form float opcodes (5-bit)
  localparam logic [4:0] AXO_FSEL    = 5'h17;
  localparam logic [4:0] AXO_FRES    = 5'h18;
  localparam logic [4:0] AXO_FRSQRTE = 5'h1A;
  localparam logic [4:0] AXO_FMADD   = 5'h1D;
  localparam logic [4:0] AXO_FADD    = 5'h15;
  localparam logic [4:0] AXO_FMUL    = 5'h19;

  // Vector VX opcodes (11-bit) and VA opcodes (6-bit)
  localparam logic [10:0] VXO_MTVSCR  = 11'h644;
  localparam logic [10:0] VXO_MFVSCR  = 11'h604;
  localparam logic [10:0] VXO_VPKUHUM = 11'h00E;
  localparam logic [10:0] VXO_VUPKHSB = 11'h20E;
  localparam logic [10:0] VXO_VMRGHB  = 11'h00C;
  localparam logic [10:0] VXO_VSPLTB  = 11'h20C;
  localparam logic [10:0] VXO_VSLO    = 11'h40C;
  localparam logic [10:0] VXO_VADDUBM = 11'h000;
  localparam logic [10:0] VXO_VADDFP  = 11'h00A;
  localparam logic [5:0]  VA_VPERM    = 6'h2B;
  localparam logic [5:0]  VA_VSEL     = 6'h2A;

  typedef enum logic [3:0] {
    RID_GRP_NONE, RID_GRP_INT, RID_GRP_FP, RID_GRP_LDST, RID_GRP_FLOW,
    RID_GRP_PCTL, RID_GRP_MCTL, RID_GRP_VINT, RID_GRP_VFP, RID_GRP_VLDST,
    RID_GRP_VPERM, RID_GRP_VPCTL, RID_GRP_VMCTL
  } rid_group_t;

  typedef enum logic [1:0] {
    RID_SZ_BYTE, RID_SZ_HALF, RID_SZ_WORD, RID_SZ_DWORD
  } rid_size_t;

  typedef struct packed {
    logic [INSN_W-1:0] word;
    logic [ADDR_W-1:0] addr;
  } rid_fetch_t;

  typedef struct packed {
    rid_group_t             group;
    rid_size_t              size;
    logic                   is_load;
    logic                   is_store;
    logic                   is_fpr;
    logic                   is_double;
    logic                   mem_write;
    logic                   reserve;
    logic                   cond_store;
    logic                   spr_move;
    logic                   msr_move;
    logic                   sync_op;
    logic                   vscr_access;
    logic                   lru_hint;
    logic                   transient;
    logic                   optional_op;
    logic                   trap_flow;
    logic                   illegal;
    logic [REG_IDX_W-1:0]   rd;
    logic [REG_IDX_W-1:0]   ra;
    logic [REG_IDX_W-1:0]   rb;
    logic [ADDR_W-1:0]      ea;
    logic [ADDR_W-1:0]      pc;
  } rid_decode_t;

endpackage

/* File: verif/rid_fetch_model.sv */
`timescale 1ns/1ps
`default_nettype none

module rid_fetch_model (
  // Clock and reset
  input  wire logic                core_clk,
  input  wire logic                arst_n,
  // Bench request
  input  wire logic                go,
  input  wire logic [31:0]         word,
  input  wire logic [31:0]         addr,
  // Fetch side
  output var  logic                fetch_valid,
  output var  rid_pkg::rid_fetch_t fetch
);
  //////////////////////////////////////////////////////////////////////////
  // Idle word inverts each cycle so a stale word is never mistaken for data
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fetch_valid <= 1'b0;
      fetch       <= '0;
    end else if (go) begin
      fetch_valid <= 1'b1;
      fetch       <= '{word: word, addr: addr};
    end else begin
      fetch_valid <= 1'b0;
      fetch.word  <= ~fetch.word;
    end
  end
endmodule // rid_fetch_model

`default_nettype wire

/* File: verif/risc_instruction_decode_test.sv */
`timescale 1ns/1ps
`default_nettype none
`define RID_CHK(a, b) begin compares++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t got %h exp %h", $time, (a), (b)); end end

module risc_instruction_decode_test;
  typedef struct {logic [3:0] g; logic [15:0] e; logic [15:0] c;} rid_exp_t;
  localparam logic [15:0] IL = 16'h0001, OP = 16'h0002, TR = 16'h0004,
    LR = 16'h0008, VS = 16'h0010, SY = 16'h0020, MS = 16'h0040,
    SP = 16'h0080, CS = 16'h0100, RV = 16'h0200, W = 16'h0400,
    S = 16'h0800, L = 16'h1000, TF = 16'h2000, HF = 16'h4000,
    WD = 16'h8000, DW = 16'hC000, NS = 16'h3FFF, AL = 16'hFFFF;
  localparam logic [3:0] GN = 4'hF, GI = rid_pkg::RID_GRP_INT,
    GF = rid_pkg::RID_GRP_FP, GL = rid_pkg::RID_GRP_LDST,
    GW = rid_pkg::RID_GRP_FLOW, GP = rid_pkg::RID_GRP_PCTL,
    GV = rid_pkg::RID_GRP_VLDST, GM = rid_pkg::RID_GRP_VPERM,
    GC = rid_pkg::RID_GRP_VPCTL, GA = rid_pkg::RID_GRP_VINT;
  //////////////////////////////////////////////////////////////////////////
  logic                 core_clk = 1'b0, arst_n = 1'b0, go = 1'b0;
  logic                 async_event = 1'b0, v_e = 1'b0, dv_e = 1'b0;
  logic [31:0]          word = '0, addr = '0, ra_value = '0, ea_e, pc_e;
  logic                 fetch_valid, dec_valid_r, divert_r;
  rid_pkg::rid_fetch_t  fetch;
  rid_pkg::rid_decode_t dec_r;
  rid_exp_t             q[$], x_e;
  logic [14:0]          rf_e;
  int                   fails = 0, compares = 0, cycles = 0;
  int                   seed = 32'h0000_707c;
  logic [10:0] pv[5] = '{rid_pkg::VXO_VPKUHUM, rid_pkg::VXO_VUPKHSB,
    rid_pkg::VXO_VMRGHB, rid_pkg::VXO_VSPLTB, rid_pkg::VXO_VSLO};
  logic [9:0]  ov[5] = '{rid_pkg::XO_ECIWX, rid_pkg::XO_ECOWX,
    rid_pkg::XO_DCBA, rid_pkg::XO_TLBLD, rid_pkg::XO_TLBLI};
  logic [5:0]  bad[4] = '{6'h00, 6'h01, 6'h02, 6'h06};

  rid_fetch_model u_rid_fetch_model (.core_clk(core_clk), .arst_n(arst_n),
    .go(go), .word(word), .addr(addr), .fetch_valid(fetch_valid),
    .fetch(fetch));
  rid_decode u_rid_decode (.core_clk(core_clk), .arst_n(arst_n),
    .fetch_valid(fetch_valid), .fetch(fetch), .ra_value(ra_value),
    .async_event(async_event), .dec_valid_r(dec_valid_r), .dec_r(dec_r),
    .divert_r(divert_r));

  always #20 core_clk = ~core_clk;

  task automatic print_verdict;
    if (fails == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  function automatic logic [31:0] xw(input logic [5:0] o, input logic [9:0] x);
    return {o, 15'h0000, x, 1'b0};
  endfunction

  // Back to back: one word per cycle, queue keeps issue order
  task automatic put(input logic [31:0] w, input logic [3:0] g,
                     input logic [15:0] e, c, input logic [1:0] mis = 2'h0);
    q.push_back('{g, e, c});
    go       <= 1'b1;
    word     <= w;
    addr     <= {$random(seed)} & 32'hFFFF_FFFC | 32'(mis);
    ra_value <= $random(seed);
    @(posedge core_clk);
  endtask
  //////////////////////////////////////////////////////////////////////////
  // Reference: what the decoder sampled at this edge shows at the next falling edge
  always @(posedge core_clk) begin
    v_e  = arst_n & fetch_valid;
    dv_e = arst_n & async_event;
    if (v_e) begin
      x_e  = q.pop_front();
      ea_e = ra_value + {{16{fetch.word[15]}}, fetch.word[15:0]};
      pc_e = fetch.addr;
      rf_e = fetch.word[25:11];
      dv_e = dv_e | ((x_e.e & (TF | IL)) != 16'h0000);
    end
    cycles++;
    if (cycles == 3000) begin
      fails++;
      print_verdict();
    end
  end

  always @(negedge core_clk) begin
    `RID_CHK(dec_valid_r, v_e)
    `RID_CHK(divert_r, dv_e)
    if (v_e) begin
      if (x_e.g != GN) `RID_CHK(4'(dec_r.group), x_e.g)
      `RID_CHK({dec_r.size, dec_r.trap_flow, dec_r.is_load, dec_r.is_store,
        dec_r.mem_write, dec_r.reserve, dec_r.cond_store, dec_r.spr_move,
        dec_r.msr_move, dec_r.sync_op, dec_r.vscr_access, dec_r.lru_hint,
        dec_r.transient, dec_r.optional_op, dec_r.illegal} & x_e.c,
        x_e.e & x_e.c)
      `RID_CHK(dec_r.ea, ea_e)
      `RID_CHK(dec_r.pc, pc_e)
      `RID_CHK({dec_r.rd, dec_r.ra, dec_r.rb}, rf_e)
    end
  end

  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    @(posedge core_clk);
    put(xw(6'h1F, rid_pkg::XO_LWARX), GL, L | RV | WD, AL);
    put(xw(6'h1F, rid_pkg::XO_STWCX) | 32'h1, GL, S | W | CS | WD, AL);
    put(xw(6'h1F, rid_pkg::XO_MFSPR), GP, SP, NS);
    put(xw(6'h1F, rid_pkg::XO_MTSPR), GP, SP, NS);
    put(xw(6'h1F, rid_pkg::XO_MFMSR), GP, MS, NS);
    put(xw(6'h1F, rid_pkg::XO_MTMSR), GP, MS, NS);
    put(xw(6'h1F, rid_pkg::XO_SYNC), GP, SY, NS);
    put(xw(6'h1F, rid_pkg::XO_EIEIO), GP, SY, NS);
    put(xw(6'h13, rid_pkg::XO_ISYNC), GP, SY, NS);
    put(xw(6'h1F, rid_pkg::XO_LBZX), GL, L, AL);
    put(xw(6'h1F, rid_pkg::XO_STHX), GL, S | W | HF, AL);
    put(xw(6'h1F, rid_pkg::XO_LFSX), GL, L | WD, AL);
    put(xw(6'h1F, rid_pkg::XO_STFDX), GL, S | W | DW, AL);
    put(xw(6'h1F, rid_pkg::XO_ADD), GI, 16'h0000, NS);
    put({6'h3F, 20'h0_0000, rid_pkg::AXO_FADD, 1'b0}, GF, 16'h0000, NS);
    put({6'h04, 15'h0000, rid_pkg::VXO_VADDUBM}, GA, 16'h0000, NS);
    put(xw(6'h1F, rid_pkg::XO_LVX), GV, L, NS);
    put(xw(6'h1F, rid_pkg::XO_LVXL), GV, L | LR | TR, NS);
    put(xw(6'h1F, rid_pkg::XO_STVXL), GV, S | W | LR | TR, NS);
    put(xw(6'h1F, rid_pkg::XO_DST) | 32'h0200_0000, GN, TR, TR | W | IL);
    put(xw(6'h1F, rid_pkg::XO_DSTST) | 32'h0200_0000, GN, TR, TR | W | IL);
    foreach (pv[i]) put({6'h04, 15'h0000, pv[i]}, GM, 16'h0000, NS);
    put({6'h04, 20'h0_0000, rid_pkg::VA_VPERM}, GM, 16'h0000, NS);
    put({6'h04, 20'h0_0000, rid_pkg::VA_VSEL}, GM, 16'h0000, NS);
    put({6'h04, 15'h0000, rid_pkg::VXO_MTVSCR}, GC, VS, NS);
    put({6'h04, 15'h0000, rid_pkg::VXO_MFVSCR}, GC, VS, NS);
    foreach (ov[i]) put(xw(6'h1F, ov[i]), GN, OP, OP | IL);
    put(xw(6'h1F, rid_pkg::XO_STFIWX), GN, OP | S | W, OP | S | W | IL);
    put({6'h3F, 20'h0_0000, rid_pkg::AXO_FSEL, 1'b0}, GF, OP, NS);
    put({6'h3B, 20'h0_0000, rid_pkg::AXO_FRES, 1'b0}, GF, OP, NS);
    put({6'h3F, 20'h0_0000, rid_pkg::AXO_FRSQRTE, 1'b0}, GF, OP, NS);
    put({6'h12, 26'h000_0000}, GW, 16'h0000, NS);
    put({6'h03, 26'h000_0000}, GW, TF, NS);
    put({6'h11, 26'h000_0002}, GN, TF, IL);
    foreach (bad[i]) put({bad[i], 26'($random(seed))}, GN, IL, IL);
    for (int i = 1; i < 4; i++) put(xw(6'h1F, rid_pkg::XO_LWARX), GN, IL, IL, 2'(i));
    repeat (16) put({6'h20, 26'($random(seed))}, GL, L | WD, AL);
    put({6'h2E, 26'h000_0000}, GL, L | WD, AL);
    async_event <= 1'b1;
    put(xw(6'h1F, rid_pkg::XO_ADD), GI, 16'h0000, NS);
    async_event <= 1'b0;
    go          <= 1'b0;
    repeat (4) @(posedge core_clk);
    arst_n <= 1'b0;
    @(posedge core_clk);
    arst_n <= 1'b1;
    put(xw(6'h1F, rid_pkg::XO_LWARX), GL, L | RV | WD, AL);
    go <= 1'b0;
    repeat (4) @(posedge core_clk);
    print_verdict();
  end
endmodule // risc_instruction_decode_test

`default_nettype wire
